// File: rtl/cci_defines.vh
// Purpose: shared offsets, field positions, reset values and timing counts
// Assumes: 250 MHz system clock
// Notes:   definitions only
`ifndef CCI_DEFINES_VH
`define CCI_DEFINES_VH

// register offsets
`define CCI_OFS_CTRL_B       8'h06
`define CCI_OFS_RSER_ADDR    8'h07
`define CCI_OFS_TGT_ADDR_0   8'h08
`define CCI_OFS_TGT_ADDR_1   8'h09
`define CCI_OFS_ALIAS_0      8'h10
`define CCI_OFS_ALIAS_1      8'h11

// fields of ctrl_channel_i2c_ctrl_b
`define CCI_BIT_SEQ_ERR      7
`define CCI_BIT_SEQ_CLR      6
`define CCI_BIT_DLY_HI       4
`define CCI_BIT_DLY_LO       3
`define CCI_BIT_RW_BLOCK     2
`define CCI_BIT_WD_FAST      1
`define CCI_BIT_WD_DIS       0
`define CCI_CTRL_B_WMASK     8'h5f

// fields of the address registers
`define CCI_BIT_FREEZE       0
`define CCI_ADDR_HI          7
`define CCI_ADDR_LO          1

// reset values
`define CCI_RST_CTRL_B       8'h00
`define CCI_RST_RSER_ADDR    8'h18
`define CCI_RST_TGT_ADDR     8'h00
`define CCI_RST_ALIAS        8'h00

// timing
`define CCI_CLK_PS           4000
`define CCI_CLK_KHZ          250000
`define CCI_DLY_BASE_NS      250
`define CCI_DLY_STEP_NS      50
`define CCI_WD_FAST_MS       50
`define CCI_WD_SLOW_MS       1000
`define CCI_RECOV_HALF_NS    5000
`define CCI_RECOV_HALF_CYC   ((`CCI_RECOV_HALF_NS * 1000) / `CCI_CLK_PS)
`define CCI_RECOV_PULSES     9

`endif

// File: rtl/cci_bus_wdog.v
// Purpose: i2c bus watchdog, detects a free or hung bus and clocks it out
// Assumes: scl and sda pins are asynchronous to clk
// Notes:   scl is open drain; scl_oe high pulls the line low
`include "cci_defines.vh"

module cci_bus_wdog #(
    parameter FAST_CYC = 12500000,
    parameter SLOW_CYC = 250000000
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output reg         scl_out,
    output reg         scl_oe,
    // control
    input  wire        wd_enable,
    input  wire        wd_fast,
    // status
    output reg         bus_free,
    output reg         recovering
);

    localparam [1:0] ST_IDLE = 2'b00;
    localparam [1:0] ST_LOW  = 2'b01;
    localparam [1:0] ST_HIGH = 2'b10;
    // integer forms first, then cut to the counter widths on purpose
    localparam integer FAST_I = FAST_CYC - 1;
    localparam integer SLOW_I = SLOW_CYC - 1;
    localparam integer HALF_I = `CCI_RECOV_HALF_CYC - 1;
    localparam integer LAST_I = `CCI_RECOV_PULSES - 1;
    localparam [27:0] FAST_LIM   = FAST_I[27:0];
    localparam [27:0] SLOW_LIM   = SLOW_I[27:0];
    localparam [11:0] HALF_LIM   = HALF_I[11:0];
    localparam [3:0]  LAST_PULSE = LAST_I[3:0];

    reg        scl_s1;
    reg        scl_s2;
    reg        scl_s3;
    reg        sda_s1;
    reg        sda_s2;
    reg        sda_s3;
    reg [1:0]  state;
    reg [27:0] idle_cnt;
    reg [11:0] half_cnt;
    reg [3:0]  pulse_cnt;
    wire       activity;
    wire [27:0] limit;

    assign activity = (scl_s2 != scl_s3) | (sda_s2 != sda_s3);
    assign limit    = wd_fast ? FAST_LIM : SLOW_LIM;

    always @(posedge clk) begin
        if (!rst_n) begin
            scl_s1 <= 1'b1;
            scl_s2 <= 1'b1;
            scl_s3 <= 1'b1;
            sda_s1 <= 1'b1;
            sda_s2 <= 1'b1;
            sda_s3 <= 1'b1;
        end else begin
            scl_s1 <= scl_in;
            scl_s2 <= scl_s1;
            scl_s3 <= scl_s2;
            sda_s1 <= sda_in;
            sda_s2 <= sda_s1;
            sda_s3 <= sda_s2;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state      <= ST_IDLE;
            idle_cnt   <= 28'h0000000;
            half_cnt   <= 12'h000;
            pulse_cnt  <= 4'h0;
            scl_out    <= 1'b0;
            scl_oe     <= 1'b0;
            bus_free   <= 1'b0;
            recovering <= 1'b0;
        end else begin
            bus_free <= 1'b0;
            if (!wd_enable) begin
                // disabling mid-recovery releases scl at once
                state      <= ST_IDLE;
                idle_cnt   <= 28'h0000000;
                scl_oe     <= 1'b0;
                recovering <= 1'b0;
            end else begin
                case (state)
                    ST_IDLE: begin
                        if (activity) begin
                            idle_cnt <= 28'h0000000;
                        end else if (idle_cnt >= limit) begin
                            idle_cnt <= 28'h0000000;
                            if (sda_s2) begin
                                bus_free <= 1'b1;
                            end else begin
                                state      <= ST_LOW;
                                scl_oe     <= 1'b1;
                                half_cnt   <= 12'h000;
                                pulse_cnt  <= 4'h0;
                                recovering <= 1'b1;
                            end
                        end else begin
                            idle_cnt <= idle_cnt + 28'h0000001;
                        end
                    end
                    ST_LOW: begin
                        if (half_cnt == HALF_LIM) begin
                            half_cnt <= 12'h000;
                            scl_oe   <= 1'b0;
                            state    <= ST_HIGH;
                        end else begin
                            half_cnt <= half_cnt + 12'h001;
                        end
                    end
                    ST_HIGH: begin
                        if (half_cnt == HALF_LIM) begin
                            half_cnt <= 12'h000;
                            if (pulse_cnt == LAST_PULSE) begin
                                state      <= ST_IDLE;
                                idle_cnt   <= 28'h0000000;
                                recovering <= 1'b0;
                            end else begin
                                pulse_cnt <= pulse_cnt + 4'h1;
                                scl_oe    <= 1'b1;
                                state     <= ST_LOW;
                            end
                        end else begin
                            half_cnt <= half_cnt + 12'h001;
                        end
                    end
                    default: begin
                        state  <= ST_IDLE;
                        scl_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

endmodule // cci_bus_wdog

// File: rtl/cci_i2c_config.v
// Purpose: control channel i2c configuration, status, alias remap, watchdog
// Assumes: register port driven by the serial control bus engine on clk
// Notes:   forward channel inputs are already on clk
//
// Summary of operation
// - forward channel sequence fault sets read-only flag in control bit 7
// - bit 6 held at one clears the flag and blocks new captures
// - bits 4:3 pick scl-to-sda delay 250, 300, 350 or 400 ns
// - bit 2 set rejects remote writes to local registers only
// - bit 1 selects watchdog timeout, one 50 ms, zero 1 s
// - bit 0 set disables the i2c bus watchdog
// - sda high and idle for the timeout marks the bus free
// - sda low and idle for the timeout drives nine scl clocks
// - remote serializer address in bits 7:1, reset 0x18, zero disables
// - forward channel auto-loads serializer address unless frozen
// - freeze bit set stops auto-load and keeps written address
// - target slot 0 at 0x08 replaces alias 0 matches, reset 0x00
// - target slot 1 at 0x09 replaces alias 1 matches, reset 0x00
// - alias slots hold 7-bit match address, zero disables the slot
`include "cci_defines.vh"

module cci_i2c_config #(
    parameter WD_FAST_CYC = `CCI_WD_FAST_MS * `CCI_CLK_KHZ,
    parameter WD_SLOW_CYC = `CCI_WD_SLOW_MS * `CCI_CLK_KHZ
) (
    // clock and reset
    input  wire        clk,
    input  wire        rst_n,
    // register port from the serial control bus engine
    input  wire        reg_wr_en,
    input  wire        reg_rd_en,
    input  wire        reg_remote,
    input  wire [7:0]  reg_addr,
    input  wire [7:0]  reg_wdata,
    output reg  [7:0]  reg_rdata,
    output reg         reg_rd_valid,
    output reg         reg_wr_refused,
    // forward control channel
    input  wire        fc_seq_err,
    input  wire        fc_addr_valid,
    input  wire [6:0]  fc_addr,
    // incoming transaction address for remap
    input  wire        xact_valid,
    input  wire [6:0]  xact_addr,
    output reg         fwd_valid,
    output reg  [6:0]  fwd_addr,
    output reg         fwd_to_ser,
    output reg         fwd_to_target,
    output reg         fwd_local,
    // sda output timing
    output reg  [7:0]  sda_delay_cyc,
    // bus pins
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        scl_out,
    output wire        scl_oe,
    // watchdog status
    output wire        bus_free,
    output wire        bus_recovering
);

    reg        seq_err;
    reg        seq_clr;
    reg [1:0]  dly_sel;
    reg        rw_block;
    reg        wd_fast;
    reg        wd_dis;
    reg [6:0]  rser_addr;
    reg        freeze;
    reg [6:0]  tgt_addr_0;
    reg [6:0]  tgt_addr_1;
    reg [6:0]  alias_0;
    reg [6:0]  alias_1;
    reg [7:0]  next_rdata;
    wire       wr_ok;
    wire       hit_ser;
    wire       hit_a0;
    wire       hit_a1;

    // ns to cycles, rounded up so the delay is never short
    function [7:0] dly_cycles;
        input [1:0] code;
        integer     ns;
        integer     cyc;
        begin
            ns  = `CCI_DLY_BASE_NS + `CCI_DLY_STEP_NS * code;
            cyc = (ns * 1000 + `CCI_CLK_PS - 1) / `CCI_CLK_PS;
            dly_cycles = cyc[7:0];
        end
    endfunction

    // zero in a match field disables it
    function match7;
        input [6:0] slot;
        input [6:0] addr;
        begin
            match7 = (slot != 7'h00) && (slot == addr);
        end
    endfunction

    // remote writes reach the registers here only while rw_block is clear
    assign wr_ok = reg_wr_en & ~(reg_remote & rw_block);

    // register writes and hardware updates
    always @(posedge clk) begin
        if (!rst_n) begin
            seq_err        <= 1'b0;
            seq_clr        <= 1'b0;
            dly_sel        <= 2'b00;
            rw_block       <= 1'b0;
            wd_fast        <= 1'b0;
            wd_dis         <= 1'b0;
            rser_addr      <= 7'h0c;
            freeze         <= 1'b0;
            tgt_addr_0     <= 7'h00;
            tgt_addr_1     <= 7'h00;
            alias_0        <= 7'h00;
            alias_1        <= 7'h00;
            reg_wr_refused <= 1'b0;
        end else begin
            reg_wr_refused <= reg_wr_en & reg_remote & rw_block;
            // clear is a level: while held, faults are not captured
            if (seq_clr) begin
                seq_err <= 1'b0;
            end else if (fc_seq_err) begin
                seq_err <= 1'b1;
            end
            // software write outranks a same-cycle auto-load
            if (fc_addr_valid && !freeze &&
                !(wr_ok && reg_addr == `CCI_OFS_RSER_ADDR)) begin
                rser_addr <= fc_addr;
            end
            if (wr_ok) begin
                case (reg_addr)
                    `CCI_OFS_CTRL_B: begin
                        seq_clr  <= reg_wdata[`CCI_BIT_SEQ_CLR];
                        dly_sel  <= reg_wdata[`CCI_BIT_DLY_HI:`CCI_BIT_DLY_LO];
                        rw_block <= reg_wdata[`CCI_BIT_RW_BLOCK];
                        wd_fast  <= reg_wdata[`CCI_BIT_WD_FAST];
                        wd_dis   <= reg_wdata[`CCI_BIT_WD_DIS];
                    end
                    `CCI_OFS_RSER_ADDR: begin
                        rser_addr <= reg_wdata[`CCI_ADDR_HI:`CCI_ADDR_LO];
                        freeze    <= reg_wdata[`CCI_BIT_FREEZE];
                    end
                    `CCI_OFS_TGT_ADDR_0: begin
                        tgt_addr_0 <= reg_wdata[`CCI_ADDR_HI:`CCI_ADDR_LO];
                    end
                    `CCI_OFS_TGT_ADDR_1: begin
                        tgt_addr_1 <= reg_wdata[`CCI_ADDR_HI:`CCI_ADDR_LO];
                    end
                    `CCI_OFS_ALIAS_0: begin
                        alias_0 <= reg_wdata[`CCI_ADDR_HI:`CCI_ADDR_LO];
                    end
                    `CCI_OFS_ALIAS_1: begin
                        alias_1 <= reg_wdata[`CCI_ADDR_HI:`CCI_ADDR_LO];
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // read mux; unmapped offsets read zero
    always @* begin
        next_rdata = 8'h00;
        case (reg_addr)
            `CCI_OFS_CTRL_B: begin
                next_rdata = {seq_err, seq_clr, 1'b0, dly_sel,
                              rw_block, wd_fast, wd_dis};
            end
            `CCI_OFS_RSER_ADDR: begin
                next_rdata = {rser_addr, freeze};
            end
            `CCI_OFS_TGT_ADDR_0: begin
                next_rdata = {tgt_addr_0, 1'b0};
            end
            `CCI_OFS_TGT_ADDR_1: begin
                next_rdata = {tgt_addr_1, 1'b0};
            end
            `CCI_OFS_ALIAS_0: begin
                next_rdata = {alias_0, 1'b0};
            end
            `CCI_OFS_ALIAS_1: begin
                next_rdata = {alias_1, 1'b0};
            end
            default: begin
                next_rdata = 8'h00;
            end
        endcase
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata     <= 8'h00;
            reg_rd_valid  <= 1'b0;
            sda_delay_cyc <= 8'h00;
        end else begin
            reg_rd_valid  <= reg_rd_en;
            if (reg_rd_en) begin
                reg_rdata <= next_rdata;
            end
            sda_delay_cyc <= dly_cycles(dly_sel);
        end
    end

    // address decode and remap of incoming transactions
    assign hit_ser = match7(rser_addr, xact_addr);
    assign hit_a0  = match7(alias_0, xact_addr);
    assign hit_a1  = match7(alias_1, xact_addr);

    always @(posedge clk) begin
        if (!rst_n) begin
            fwd_valid     <= 1'b0;
            fwd_addr      <= 7'h00;
            fwd_to_ser    <= 1'b0;
            fwd_to_target <= 1'b0;
            fwd_local     <= 1'b0;
        end else begin
            fwd_valid <= xact_valid;
            if (xact_valid) begin
                fwd_to_ser    <= hit_ser;
                fwd_to_target <= ~hit_ser & (hit_a0 | hit_a1);
                fwd_local     <= ~hit_ser & ~hit_a0 & ~hit_a1;
                if (hit_ser) begin
                    fwd_addr <= xact_addr;
                end else if (hit_a0) begin
                    fwd_addr <= tgt_addr_0;
                end else if (hit_a1) begin
                    fwd_addr <= tgt_addr_1;
                end else begin
                    fwd_addr <= xact_addr;
                end
            end
        end
    end

    cci_bus_wdog #(
        .FAST_CYC (WD_FAST_CYC),
        .SLOW_CYC (WD_SLOW_CYC)
    ) u_wdog (
        .clk        (clk),
        .rst_n      (rst_n),
        .scl_in     (scl_in),
        .sda_in     (sda_in),
        .scl_out    (scl_out),
        .scl_oe     (scl_oe),
        .wd_enable  (~wd_dis),
        .wd_fast    (wd_fast),
        .bus_free   (bus_free),
        .recovering (bus_recovering)
    );

endmodule // cci_i2c_config

// File: verification/cci_cfg_props.sv
// Purpose: port checker for the i2c configuration block
// Assumes: one clk domain, synchronous active-low reset
// Notes:   bound to every instance of the block
module cci_cfg_props #(
    parameter WD_FAST_CYC = 200,
    parameter WD_SLOW_CYC = 400
) (
    // clock and reset
    input wire       clk,
    input wire       rst_n,
    // register port
    input wire       reg_wr_en,
    input wire       reg_rd_en,
    input wire       reg_remote,
    input wire [7:0] reg_addr,
    input wire [7:0] reg_rdata,
    input wire       reg_rd_valid,
    input wire       reg_wr_refused,
    // remap path
    input wire       xact_valid,
    input wire [6:0] xact_addr,
    input wire       fwd_valid,
    input wire [6:0] fwd_addr,
    input wire       fwd_to_ser,
    input wire       fwd_to_target,
    input wire       fwd_local,
    // timing and bus
    input wire [7:0] sda_delay_cyc,
    input wire       sda_in,
    input wire       scl_oe,
    input wire       bus_free,
    input wire       bus_recovering
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    a_rd_answer: assert property (reg_rd_en |=> reg_rd_valid)
        else $error("read got no answer");
    a_refuse_cause: assert property (
        reg_wr_refused |-> $past(reg_wr_en && reg_remote))
        else $error("refusal without a remote write");
    a_fwd_follow: assert property (xact_valid |=> fwd_valid &&
        $onehot({fwd_to_ser, fwd_to_target, fwd_local}))
        else $error("remap answer missing or ambiguous");
    a_local_keep: assert property (
        fwd_valid && fwd_local |-> fwd_addr == $past(xact_addr))
        else $error("unmatched address altered");
    // first edge after release still shows the reset value
    a_delay_legal: assert property ($past(rst_n) |->
        sda_delay_cyc inside {8'h3f, 8'h4b, 8'h58, 8'h64})
        else $error("sda delay outside the four steps");
    a_rsvd_ctrl: assert property (
        reg_rd_valid && $past(reg_addr) == 8'h06 |-> !reg_rdata[5])
        else $error("reserved control bit reads one");
    a_free_pulse: assert property (bus_free |=> !bus_free)
        else $error("bus free longer than a pulse");
    a_free_sda_high: assert property (bus_free |-> $past(sda_in, 3))
        else $error("bus free with sda low");
    a_recov_sda_low: assert property (
        $rose(bus_recovering) |-> !$past(sda_in, 3))
        else $error("recovery with sda high");
    a_pull_in_recov: assert property (scl_oe |-> bus_recovering)
        else $error("scl pulled outside recovery");
    cover property (reg_wr_refused);
    cover property (bus_free);
    cover property ($rose(bus_recovering));
endmodule // cci_cfg_props

bind cci_i2c_config cci_cfg_props #(
    .WD_FAST_CYC(WD_FAST_CYC),
    .WD_SLOW_CYC(WD_SLOW_CYC)
) u_props (
    .clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_remote, .reg_addr,
    .reg_rdata, .reg_rd_valid, .reg_wr_refused, .xact_valid, .xact_addr,
    .fwd_valid, .fwd_addr, .fwd_to_ser, .fwd_to_target, .fwd_local,
    .sda_delay_cyc, .sda_in, .scl_oe, .bus_free, .bus_recovering
);

// File: verification/cci_bus_pins.sv
// Purpose: i2c bus lines as the far side sees them
// Assumes: pull-ups on both lines
// Notes:   sda level is commanded by the bench
module cci_bus_pins (
    // design side
    input  wire scl_oe,
    input  wire scl_out,
    // bench command
    input  wire sda_low,
    // resolved lines
    output wire scl_line,
    output wire sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    // released line floats to the pull-up, not the last level
    assign scl_line = scl_oe ? scl_out : 1'b1;
    assign sda_line = sda_low ? 1'b0 : 1'b1;
endmodule // cci_bus_pins

// File: verification/ctrl_channel_i2c_config_tb_top.sv
// Purpose: directed bench for the i2c configuration block
// Assumes: watchdog counts shortened to FAST and SLOW
// Notes:   inputs change 1 ns after the rising edge
module ctrl_channel_i2c_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam FAST = 200;
    localparam SLOW = 400;
    localparam [31:0] DLY = {8'h3f, 8'h4b, 8'h58, 8'h64};
    logic       clk = 0, rst_n = 0, sda_low = 0;
    logic       reg_wr_en = 0, reg_rd_en = 0, reg_remote = 0;
    logic [7:0] reg_addr = 0, reg_wdata = 0, d;
    logic       fc_seq_err = 0, fc_addr_valid = 0, xact_valid = 0;
    logic [6:0] fc_addr = 0, xact_addr = 0;
    wire  [7:0] reg_rdata, sda_delay_cyc;
    wire  [6:0] fwd_addr;
    wire        reg_rd_valid, reg_wr_refused, fwd_valid, fwd_to_ser;
    wire        fwd_to_target, fwd_local, scl_out, scl_oe, bus_free;
    wire        bus_recovering, scl_line, sda_line;
    integer     n_fail = 0, total_checks = 0, n, i, pulses = 0;
    always #2 clk = ~clk;
    always @(posedge scl_oe) pulses = pulses + 1;
    cci_i2c_config #(.WD_FAST_CYC(FAST), .WD_SLOW_CYC(SLOW)) dut (
        .clk, .rst_n, .reg_wr_en, .reg_rd_en, .reg_remote, .reg_addr,
        .reg_wdata, .reg_rdata, .reg_rd_valid, .reg_wr_refused,
        .fc_seq_err, .fc_addr_valid, .fc_addr, .xact_valid, .xact_addr,
        .fwd_valid, .fwd_addr, .fwd_to_ser, .fwd_to_target, .fwd_local,
        .sda_delay_cyc, .scl_in(scl_line), .sda_in(sda_line), .scl_out,
        .scl_oe, .bus_free, .bus_recovering);
    cci_bus_pins u_pins (.scl_oe, .scl_out, .sda_low, .scl_line, .sda_line);
    task chk(input [7:0] got, input [7:0] exp);
        total_checks = total_checks + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task wr(input [7:0] a, input [7:0] v, input r);
        @(posedge clk);
        #1 reg_wr_en = 1;
        reg_addr = a;
        reg_wdata = v;
        reg_remote = r;
        @(posedge clk);
        #1 reg_wr_en = 0;
        reg_remote = 0;
    endtask
    task rc(input [7:0] a, input [7:0] exp);
        @(posedge clk);
        #1 reg_rd_en = 1;
        reg_addr = a;
        @(posedge clk);
        #1 reg_rd_en = 0;
        chk(reg_rd_valid, 1);
        chk(reg_rdata, exp);
    endtask
    // s: 0 sequence fault, 1 address load, 2 transaction
    task strobe(input integer s, input [6:0] a);
        @(posedge clk);
        #1 {fc_seq_err, fc_addr_valid, xact_valid} = 3'b100 >> s;
        fc_addr = a;
        xact_addr = a;
        @(posedge clk);
        #1 {fc_seq_err, fc_addr_valid, xact_valid} = 3'b000;
    endtask
    // exp bit 7 set: address not compared
    task xa(input [6:0] a, input [7:0] exp, input [2:0] k);
        strobe(2, a);
        chk(fwd_valid, 1);
        chk({5'h00, fwd_to_ser, fwd_to_target, fwd_local}, {5'h00, k});
        if (!exp[7]) chk({1'b0, fwd_addr}, exp);
    endtask
    // s: 0 bus free pulse, 1 recovery starts, 2 recovery ends
    task wt(input integer s, input integer lim);
        n = 0;
        while ((s == 0 ? bus_free : bus_recovering ^ (s == 2)) !== 1'b1) begin
            @(posedge clk);
            #1 n = n + 1;
            if (n > lim) begin
                n_fail = n_fail + 1;
                stop_test;
            end
        end
    endtask
    // an sda edge restarts the idle count
    task kick;
        @(posedge clk);
        #1 sda_low = 1;
        repeat (4) @(posedge clk);
        #1 sda_low = 0;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        #1 rst_n = 1;
        rc(8'h06, 8'h00);
        rc(8'h07, 8'h18);
        rc(8'h08, 8'h00);
        rc(8'h09, 8'h00);
        rc(8'h10, 8'h00);
        rc(8'h0a, 8'h00);
        wr(8'h06, 8'hff, 0);
        rc(8'h06, 8'h5f);
        for (i = 0; i < 4; i++) begin
            wr(8'h06, 8'(i * 8 + 1), 0);
            repeat (2) @(posedge clk);
            #1 chk(sda_delay_cyc, DLY[31 - 8 * i -: 8]);
        end
        $display("test reset and control done");
        wr(8'h06, 8'h01, 0);
        strobe(0, 0);
        rc(8'h06, 8'h81);
        wr(8'h06, 8'h41, 0);
        strobe(0, 0);
        rc(8'h06, 8'h41);
        wr(8'h06, 8'h01, 0);
        rc(8'h06, 8'h01);
        strobe(0, 0);
        rc(8'h06, 8'h81);
        $display("test sequence fault done");
        wr(8'h06, 8'h05, 0);
        chk(reg_wr_refused, 0);
        wr(8'h08, 8'h5a, 1);
        chk(reg_wr_refused, 1);
        rc(8'h08, 8'h00);
        wr(8'h06, 8'h01, 0);
        wr(8'h08, 8'ha5, 1);
        chk(reg_wr_refused, 0);
        rc(8'h08, 8'ha4);
        strobe(1, 7'h2a);
        rc(8'h07, 8'h54);
        wr(8'h07, 8'h67, 0);
        strobe(1, 7'h11);
        rc(8'h07, 8'h67);
        $display("test access and address load done");
        wr(8'h10, 8'h40, 0);
        wr(8'h09, 8'h66, 0);
        wr(8'h11, 8'h43, 0);
        rc(8'h11, 8'h42);
        xa(7'h20, 8'h52, 3'b010);
        xa(7'h21, 8'h33, 3'b010);
        xa(7'h33, 8'h33, 3'b100);
        xa(7'h05, 8'h05, 3'b001);
        wr(8'h11, 8'h00, 0);
        wr(8'h07, 8'h01, 0);
        xa(7'h00, 8'h00, 3'b001);
        xa(7'h33, 8'h33, 3'b001);
        $display("test remap done");
        wr(8'h06, 8'h02, 0);
        kick;
        wt(0, FAST + 50);
        chk(8'(n >= FAST && n <= FAST + 8), 1);
        wr(8'h06, 8'h00, 0);
        kick;
        wt(0, SLOW + 50);
        chk(8'(n >= SLOW && n <= SLOW + 8), 1);
        wr(8'h06, 8'h01, 0);
        kick;
        d = 0;
        repeat (SLOW + 50) begin
            @(posedge clk);
            #1 d = d | bus_free;
        end
        chk(d, 0);
        wr(8'h06, 8'h02, 0);
        @(posedge clk);
        #1 sda_low = 1;
        pulses = 0;
        wt(1, FAST + 50);
        chk({7'h00, scl_line}, 8'h00);
        wt(2, 30000);
        chk(pulses[7:0], 9);
        sda_low = 0;
        $display("test watchdog done");
        stop_test;
    end
endmodule // ctrl_channel_i2c_config_tb_top
